// *** hw/xmc_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef XMC_REGS_SVH
`define XMC_REGS_SVH

// ------------------------------------------------------------
// register map (apb byte addresses)
// ------------------------------------------------------------
`define XMC_TIMING_OFS     12'h000
`define XMC_PINCTL_OFS     12'h004
`define XMC_STATUS_OFS     12'h008
`define XMC_TIMING_RST     8'h00
`define XMC_PINCTL_RST     8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define XMC_ENABLE_BIT     7
`define XMC_SECTOR_HI      6
`define XMC_SECTOR_LO      4
`define XMC_UPWAIT_HI      3
`define XMC_UPWAIT_LO      2
`define XMC_LOWAIT_HI      1
`define XMC_LOWAIT_LO      0
`define XMC_KEEPER_BIT     7
`define XMC_MASK_HI        2
`define XMC_MASK_LO        0
`define XMC_PINCTL_WMASK   8'h87

// ------------------------------------------------------------
// address map and timing counts
// ------------------------------------------------------------
`define XMC_EXT_BASE       16'h2100
`define XMC_EXT_BASE_SMALL 16'h1100
`define XMC_STROBE_MAX     2'h2

`endif

// *** hw/xmc_pkg.sv ***
// types shared by the external memory interface controller
package xmc_pkg;

  // access phases of one external cycle
  typedef enum logic [2:0] {
    XMC_IDLE,
    XMC_ADDR,
    XMC_STROBE,
    XMC_WAIT,
    XMC_HOLD,
    XMC_GAP
  } xmc_phase_type;

  // wait-state codes
  typedef enum logic [1:0] {
    XMC_WS_NONE,
    XMC_WS_ONE,
    XMC_WS_TWO,
    XMC_WS_TWO_GAP
  } xmc_wait_type;

endpackage : xmc_pkg

// *** hw/xmc_sector_decode.sv ***
// sector selection and wait-state lookup for one access address
`timescale 1ns/100ps

`include "xmc_regs.svh"

module xmc_sector_decode
  import xmc_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic [2:0]  sector_limit_sel,
  input  wire logic [1:0]  upper_wait,
  input  wire logic [1:0]  lower_wait,
  input  wire logic        small_variant,
  output      logic        is_external,
  output      xmc_wait_type wait_code
);

  logic [2:0] top3;
  logic       in_upper;

  // upper sector starts at limit code times 0x2000, codes 00x mean no split
  always_comb begin
    top3     = addr[15:13];
    in_upper = (sector_limit_sel[2:1] == 2'h0) ||
               (top3 >= sector_limit_sel);
    wait_code = in_upper ? xmc_wait_type'(upper_wait)
                         : xmc_wait_type'(lower_wait);
    // low part of data space belongs to internal memory
    is_external = small_variant ? (addr >= `XMC_EXT_BASE_SMALL)
                                : (addr >= `XMC_EXT_BASE);
  end

endmodule : xmc_sector_decode

// *** hw/xmc_ctrl.sv ***
// external memory interface: apb registers and access sequencer
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps

`include "xmc_regs.svh"

module xmc_ctrl
  import xmc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        small_variant,
  input  wire logic        cpu_req,
  input  wire logic        cpu_write,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_next_ram,
  output      logic        cpu_done,
  output      logic [7:0]  cpu_rdata,
  input  wire logic [7:0]  port_addr_out,
  input  wire logic [7:0]  port_addr_oe,
  input  wire logic [7:0]  port_data_out,
  input  wire logic [7:0]  port_data_oe,
  input  wire logic [7:0]  muxed_addr_data_in,
  output      logic [7:0]  muxed_addr_data_out,
  output      logic [7:0]  muxed_addr_data_oe,
  output      logic [7:0]  high_addr_bus_out,
  output      logic [7:0]  high_addr_bus_oe,
  output      logic        addr_latch_out,
  output      logic        addr_latch_oe,
  output      logic        read_strobe_n_out,
  output      logic        write_strobe_n_out,
  output      logic        strobes_oe,
  output      logic        bus_keeper_enable_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    timing;
    logic [7:0]    pinctl;
    logic          ready;
    logic          slverr;
    logic [31:0]   rdata;
    xmc_phase_type phase;
    logic [1:0]    cnt;
    logic          gap;
    logic          ext;
    logic          wr;
    logic [15:0]   addr;
    logic [7:0]    wdata;
    logic          next_ram;
    logic [7:0]    din_s1;
    logic [7:0]    din_s2;
    logic          done;
    logic [7:0]    cpu_rd;
    logic [7:0]    ad_out;
    logic [7:0]    ad_oe;
    logic [7:0]    ha_out;
    logic [7:0]    ha_oe;
    logic          ale;
    logic          ale_oe;
    logic          rd_n;
    logic          wr_n;
    logic          str_oe;
    logic          keeper;
  } xmc_state_type;

  xmc_state_type s_q;
  xmc_state_type s_d;

  logic         dec_ext;
  xmc_wait_type dec_wait;
  logic         en;
  logic [2:0]   hmask;
  logic [7:0]   addr_pins;
  logic         apb_acc;

  assign en    = s_q.timing[`XMC_ENABLE_BIT];
  assign hmask = s_q.pinctl[`XMC_MASK_HI:`XMC_MASK_LO];

  // ------------------------------------------------------------
  // sector decode of the incoming address
  // ------------------------------------------------------------
  xmc_sector_decode u_dec (
    .addr             (cpu_addr),
    .sector_limit_sel (s_q.timing[`XMC_SECTOR_HI:`XMC_SECTOR_LO]),
    .upper_wait       (s_q.timing[`XMC_UPWAIT_HI:`XMC_UPWAIT_LO]),
    .lower_wait       (s_q.timing[`XMC_LOWAIT_HI:`XMC_LOWAIT_LO]),
    .small_variant    (small_variant),
    .is_external      (dec_ext),
    .wait_code        (dec_wait)
  );

  // pins kept as address: mask n keeps 8-n bits, 111 keeps none
  always_comb begin
    addr_pins = 8'hff;
    if (hmask == 3'h7) begin
      addr_pins = 8'h00;
    end else begin
      addr_pins = 8'hff >> hmask;
    end
  end

  assign apb_acc = psel && penable && !s_q.ready;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.ready  = 1'b0;
    s_d.slverr = 1'b0;
    s_d.done   = 1'b0;
    // pad data is off-domain, so two flops before use
    s_d.din_s1 = muxed_addr_data_in;
    s_d.din_s2 = s_q.din_s1;

    // apb slave: one wait cycle, unmapped gives pslverr
    if (apb_acc) begin
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      case (paddr)
        `XMC_TIMING_OFS: begin
          if (pwrite) s_d.timing = pwdata[7:0];
          s_d.rdata = {24'h00_0000, s_q.timing};
        end
        `XMC_PINCTL_OFS: begin
          // reserved bits are never stored so they read zero
          if (pwrite) s_d.pinctl = pwdata[7:0] & `XMC_PINCTL_WMASK;
          s_d.rdata = {24'h00_0000, s_q.pinctl};
        end
        `XMC_STATUS_OFS: begin
          s_d.rdata = {28'h000_0000, s_q.ext, 3'(s_q.phase)};
        end
        default: begin
          s_d.slverr = 1'b1;
        end
      endcase
    end

    // access sequencer
    case (s_q.phase)
      XMC_IDLE: begin
        s_d.ale = 1'b0;
        // the cycle that shows done still sees the old request, so skip it
        if (cpu_req && en && !s_q.done) begin
          // gap of code 11 after an external access delays the next address by one cycle
          if (s_q.gap) begin
            s_d.gap = 1'b0;
          end else begin
            s_d.addr     = cpu_addr;
            s_d.wr       = cpu_write;
            s_d.wdata    = cpu_wdata;
            s_d.next_ram = cpu_next_ram;
            s_d.ext      = dec_ext;
            s_d.cnt      = (dec_wait == XMC_WS_NONE) ? 2'h0 :
                           (dec_wait == XMC_WS_ONE)  ? 2'h1
                                      : `XMC_STROBE_MAX;
            s_d.gap      = (dec_wait == XMC_WS_TWO_GAP) && dec_ext;
            s_d.ad_out   = cpu_addr[7:0];
            s_d.ad_oe    = 8'hff;
            s_d.ha_out   = cpu_addr[15:8];
            s_d.ale      = 1'b1;
            s_d.phase    = XMC_ADDR;
          end
        end else if (!s_q.done) begin
          s_d.gap = 1'b0;
        end
      end
      XMC_ADDR: begin
        // latch falls on the same edge that the low byte is replaced by write data or released
        s_d.ale = 1'b0;
        if (s_q.wr) begin
          s_d.ad_out = s_q.wdata;
        end else begin
          s_d.ad_oe = 8'h00;
        end
        // only external accesses move the strobes
        s_d.rd_n  = !(s_q.ext && !s_q.wr);
        s_d.wr_n  = !(s_q.ext && s_q.wr);
        s_d.phase = XMC_STROBE;
      end
      XMC_STROBE: begin
        if (s_q.cnt != 2'h0) begin
          s_d.cnt = s_q.cnt - 2'h1;
        end else begin
          // read data sampled through synchroniser at strobe end
          if (!s_q.wr) s_d.cpu_rd = s_q.din_s2;
          s_d.rd_n  = 1'b1;
          s_d.wr_n  = 1'b1;
          s_d.phase = XMC_HOLD;
        end
      end
      XMC_HOLD: begin
        s_d.ad_oe = 8'h00;
        s_d.ale   = s_q.next_ram;
        s_d.done  = 1'b1;
        s_d.phase = XMC_IDLE;
      end
      default: begin
        s_d.phase = XMC_IDLE;
      end
    endcase

    // disabled: port settings own the pins again
    if (!en) begin
      s_d.ad_out = port_data_out;
      s_d.ad_oe  = port_data_oe;
      s_d.ha_out = port_addr_out;
      s_d.ha_oe  = port_addr_oe;
      s_d.ale_oe = 1'b0;
      s_d.str_oe = 1'b0;
      s_d.rd_n   = 1'b1;
      s_d.wr_n   = 1'b1;
      s_d.ale    = 1'b0;
      s_d.phase  = XMC_IDLE;
      s_d.done   = cpu_req && !s_q.done;
    end else begin
      // released high pins fall back to port value and direction
      s_d.ha_out = (s_d.ha_out & addr_pins) |
                   (port_addr_out & ~addr_pins);
      s_d.ha_oe  = addr_pins | (port_addr_oe & ~addr_pins);
      s_d.ale_oe = 1'b1;
      s_d.str_oe = 1'b1;
    end

    // keeper follows its own bit only, not the enable
    s_d.keeper = s_q.pinctl[`XMC_KEEPER_BIT];
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.timing <= `XMC_TIMING_RST;
      s_q.pinctl <= `XMC_PINCTL_RST;
      s_q.phase  <= XMC_IDLE;
      s_q.rd_n   <= 1'b1;
      s_q.wr_n   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign prdata                = s_q.rdata;
  assign pready                = s_q.ready;
  assign pslverr               = s_q.slverr;
  assign cpu_done              = s_q.done;
  assign cpu_rdata             = s_q.cpu_rd;
  assign muxed_addr_data_out   = s_q.ad_out;
  assign muxed_addr_data_oe    = s_q.ad_oe;
  assign high_addr_bus_out     = s_q.ha_out;
  assign high_addr_bus_oe      = s_q.ha_oe;
  assign addr_latch_out        = s_q.ale;
  assign addr_latch_oe         = s_q.ale_oe;
  assign read_strobe_n_out     = s_q.rd_n;
  assign write_strobe_n_out    = s_q.wr_n;
  assign strobes_oe            = s_q.str_oe;
  assign bus_keeper_enable_out = s_q.keeper;

endmodule : xmc_ctrl

// *** verification/xmc_ctrl_properties.sv ***
// port-level checks of the external memory interface controller
`timescale 1ns/100ps
module xmc_ctrl_properties (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready,
  input wire logic        pslverr, small_variant, cpu_req, cpu_done,
  input wire logic        cpu_next_ram, addr_latch_out, read_strobe_n_out,
  input wire logic        write_strobe_n_out, bus_keeper_enable_out,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  port_addr_out, port_addr_oe, port_data_oe,
  input wire logic [7:0]  muxed_addr_data_out, muxed_addr_data_oe,
  input wire logic [7:0]  high_addr_bus_out, high_addr_bus_oe
);
  logic [7:0] sh_a_q, sh_b_q, rel;
  logic [2:0] low_q, wait_n;
  logic [1:0] code;
  logic       live_q, wr_ok, ext;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // expected wait count of the current address, released high pins
  assign wr_ok = psel & penable & pready & pwrite & !pslverr;
  assign ext = !small_variant && cpu_addr >= 16'h2100;
  assign code = (sh_a_q[6:5] == 2'h0 || cpu_addr[15:13] >= sh_a_q[6:4]) ?
                sh_a_q[3:2] : sh_a_q[1:0];
  assign wait_n = (code == 2'h0) ? 3'h0 : (code == 2'h1) ? 3'h1 : 3'h2;
  assign rel = (sh_b_q[2:0] == 3'h7) ? 8'hff :
               8'(8'hff << (4'h8 - 4'(sh_b_q[2:0])));
  // shadow registers lag the design by one edge, as its outputs do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_a_q <= 8'h00;
      sh_b_q <= 8'h00;
      low_q  <= 3'h0;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      low_q  <= (read_strobe_n_out & write_strobe_n_out) ? 3'h0 : low_q + 3'h1;
      if (wr_ok && paddr == 12'h000) sh_a_q <= pwdata[7:0];
      if (wr_ok && paddr == 12'h004) sh_b_q <= pwdata[7:0];
    end
  end
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait state");
  a_reserved_zero: assert property (
    pready && !pwrite && !pslverr && paddr == 12'h004
    |-> {prdata[31:8], prdata[6:3]} == 28'h000_0000)
    else $error("pin control reserved bits read non-zero");
  a_strobe_len: assert property (
    live_q && $rose(read_strobe_n_out & write_strobe_n_out)
    |-> low_q == wait_n + 3'h1)
    else $error("strobe length differs from sector wait code");
  a_internal_quiet: assert property (
    cpu_req && !small_variant && cpu_addr < 16'h2100
    |-> read_strobe_n_out && write_strobe_n_out)
    else $error("strobe toggled on internal access");
  a_off_port: assert property (
    live_q && !sh_a_q[7] && !$past(sh_a_q[7])
    |-> high_addr_bus_oe == $past(port_addr_oe) &&
        high_addr_bus_out == $past(port_addr_out) &&
        muxed_addr_data_oe == $past(port_data_oe))
    else $error("disabled interface does not follow port settings");
  a_release_pins: assert property (
    live_q && sh_a_q[7] && $stable(sh_b_q)
    |-> ((high_addr_bus_oe ^ $past(port_addr_oe)) & rel) == 8'h00)
    else $error("released high pins do not follow port direction");
  a_addr_high: assert property (
    sh_a_q[7] && $rose(addr_latch_out) && cpu_req && !cpu_done && ext
    |-> (high_addr_bus_oe | rel) == 8'hff &&
        ((high_addr_bus_out ^ cpu_addr[15:8]) & ~rel) == 8'h00)
    else $error("high address pins wrong at latch strobe");
  a_latch_addr: assert property (
    $fell(addr_latch_out) && !$past(cpu_done) && cpu_req && ext
    |-> $past(muxed_addr_data_out) == $past(cpu_addr[7:0]) &&
        $past(muxed_addr_data_oe) == 8'hff)
    else $error("low address not valid at latch strobe fall");
  a_trail_latch: assert property (
    sh_a_q[7] && cpu_done |-> addr_latch_out == $past(cpu_next_ram))
    else $error("trailing latch pulse does not follow next-ram flag");
  a_keeper_bit: assert property (
    live_q && $stable(sh_b_q) |-> bus_keeper_enable_out == sh_b_q[7])
    else $error("bus keeper enable does not follow its bit");
endmodule : xmc_ctrl_properties

bind xmc_ctrl xmc_ctrl_properties i_xmc_ctrl_properties (.*);

// *** verification/xmc_sram_model.sv ***
// behavioural external sram behind an address latch clocked on pclk edges
`timescale 1ns/100ps
module xmc_sram_model (
  input  wire logic       pclk, addr_latch_out, bus_keeper_enable_out,
  input  wire logic       read_strobe_n_out, write_strobe_n_out,
  input  wire logic [7:0] muxed_addr_data_out, muxed_addr_data_oe,
  input  wire logic [7:0] high_addr_bus_out,
  output      logic [7:0] muxed_addr_data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  logic [7:0] last = 8'h00;
  logic [7:0] far;
  // address taken on clock edges while the strobe is high, so the data
  // launched with the strobe fall cannot race into the latch
  // write data is taken while the write strobe is active
  always @(posedge pclk) begin
    if (addr_latch_out) lat <= muxed_addr_data_out;
    if (!write_strobe_n_out) mem[{high_addr_bus_out, lat}] <= muxed_addr_data_out;
    last <= muxed_addr_data_in;
  end
  // read data only under the strobe; a released bus keeps or flips
  assign far = !read_strobe_n_out ? mem[{high_addr_bus_out, lat}] :
               bus_keeper_enable_out ? last : ~last;
  assign muxed_addr_data_in = (muxed_addr_data_oe & muxed_addr_data_out) |
                              (~muxed_addr_data_oe & far);
endmodule : xmc_sram_model

// *** verification/external_memory_interface_ctrl_tb.sv ***
// self-checking bench: apb register access and external cycles
`timescale 1ns/100ps
module external_memory_interface_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        small_variant, cpu_req, cpu_write, cpu_next_ram, cpu_done;
  logic        addr_latch_out, addr_latch_oe, read_strobe_n_out;
  logic        write_strobe_n_out, strobes_oe, bus_keeper_enable_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, port_addr_out, port_addr_oe;
  logic [7:0]  port_data_out, port_data_oe, muxed_addr_data_in;
  logic [7:0]  muxed_addr_data_out, muxed_addr_data_oe;
  logic [7:0]  high_addr_bus_out, high_addr_bus_oe;
  int          err_count, checks_done;

  xmc_ctrl       i_xmc_ctrl (.*);
  xmc_sram_model i_xmc_sram_model (.*);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // cpu access held until done is sampled; request stays up between calls
  task automatic cpu(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input int exp);
    int n;
    n = 0;
    cpu_req <= 1'b1;
    cpu_write <= wr;
    cpu_addr <= a;
    cpu_wdata <= d;
    do begin
      @(posedge pclk);
      n++;
    end while (cpu_done !== 1'b1 && n < 30);
    check("cpu cycles", n, exp);
  endtask : cpu

  // drops the request in the step in which done was seen
  task automatic stop;
    cpu_req <= 1'b0;
    @(posedge pclk);
  endtask : stop

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    {presetn, psel, penable, pwrite, small_variant, cpu_req} = '0;
    {cpu_write, cpu_next_ram, paddr, pwdata, cpu_addr, cpu_wdata} = '0;
    {port_addr_out, port_data_out, port_data_oe} = '0;
    port_addr_oe = 8'hff;
    err_count = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    check("timing reset", q, 32'h0);
    apb(0, 12'h004, 0);
    check("pin reset", q, 32'h0);
    apb(1, 12'h004, 32'hff);
    apb(0, 12'h004, 0);
    check("pin reserved", q, 32'h87);
    check("keeper off-mode", bus_keeper_enable_out, 1'b1);
    apb(0, 12'h010, 0);
    check("unmapped error", e, 1'b1);
    $display("test registers done");
    cpu(1, 16'h4000, 8'h11, 2);
    stop;
    // bit7 released and port drives it low: 0x8000 lands at 0x0000
    apb(1, 12'h004, 32'h81);
    apb(1, 12'h000, 32'hcd);
    cpu(1, 16'h2100, 8'h21, 6);
    cpu(1, 16'h7fff, 8'h7f, 6);
    cpu(1, 16'h8000, 8'ha5, 7);
    cpu(1, 16'h8001, 8'h5a, 8);
    stop;
    cpu(1, 16'h2000, 8'h33, 6);
    stop;
    check("mem 2100", i_xmc_sram_model.mem[16'h2100], 8'h21);
    check("mem 0000", i_xmc_sram_model.mem[16'h0000], 8'ha5);
    check("mem 0001", i_xmc_sram_model.mem[16'h0001], 8'h5a);
    check("mem 2000", i_xmc_sram_model.mem[16'h2000], 8'hxx);
    cpu(0, 16'h8000, 8'h00, 7);
    check("read data", cpu_rdata, 8'ha5);
    stop;
    $display("test external cycles done");
    cpu_next_ram <= 1'b1;
    // upper code 00, lower code 10 at every sector limit
    for (int l = 0; l < 8; l++) begin
      apb(1, 12'h000, 32'(32'h82 | (l << 4)));
      cpu(1, 16'h5fff, 8'(l), (l <= 2) ? 5 : 7);
      stop;
    end
    $display("test sector limits done");
    apb(1, 12'h000, 0);
    port_addr_out <= 8'h3c;
    apb(1, 12'h004, 0);
    repeat (4) @(posedge pclk);
    check("port pins", high_addr_bus_out, 8'h3c);
    check("keeper off", bus_keeper_enable_out, 1'b0);
    $display("test disable done");
    summarize();
  end

  // a hung handshake ends the run well past the expected length
  initial begin
    repeat (3000) @(posedge pclk);
    err_count++;
    summarize();
  end
endmodule : external_memory_interface_ctrl_tb
